// ==== mtm_dac_model.sv ====
`timescale 1ns/10ps
// stand-in for the channel converter: takes every word, never stalls
module mtm_dac_model (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic [17:0] dac_i,
    input  wire logic        valid_i,
    output logic      [31:0] count_o,
    output logic      [17:0] last_o
);
    // count words and keep the latest one
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            count_o <= 32'h0;
            last_o  <= 18'h0;
        end else if (valid_i) begin
            count_o <= count_o + 32'h1;
            last_o  <= dac_i;
        end
    end
endmodule

// ==== mtm_modulator.sv ====
`timescale 1ns/10ps
module mtm_modulator #(
    parameter int N_CHANNELS = mtm_pkg::CH_COUNT_LO
) (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic [31:0] osc_inc_i [mtm_pkg::NUM_OSC],
    input  wire logic [29:0] osc_hz_i  [mtm_pkg::NUM_OSC],
    input  wire logic [15:0] sample_i,
    input  wire logic        sample_valid_i,
    output logic      [17:0] dac_o,
    output logic             dac_valid_o
);
    localparam int G = mtm_pkg::NUM_GEN;

    // byte-lane merge for partial writes
    function automatic logic [31:0] mtm_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                              input logic [3:0] sel);
        logic [31:0] r;
        r = old_v;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) r[8*b +: 8] = new_v[8*b +: 8];
        end
        return r;
    endfunction

    // register state
    logic                  ack_q, ack_d;
    logic [31:0]           rd_q, rd_d;
    logic                  adv_q, adv_d;
    logic [G-1:0][3:0]     sel_q, sel_d;
    logic [G-1:0][9:0]     harm_q, harm_d;
    logic [G-1:0][15:0]    phase_q, phase_d;
    logic [G-1:0][15:0]    amp_q, amp_d;
    logic                  wr;
    logic                  gen_hit;
    logic [1:0]            gi;
    logic [31:0]           m;

    // datapath state
    logic [1:0]            idx_q, idx_d;
    logic [G-1:0][15:0]    env_q, env_d;
    logic [15:0]           byp_q, byp_d;
    logic                  tick_q, adv_t_q, adv_t_d;
    logic [17:0]           dac_q, dac_d;
    logic                  vld_q;
    logic signed [17:0]    sum_w;
    logic signed [15:0]    sin_w [G];
    logic        [31:0]    inc_w [G];

    // wishbone decode and register next state
    always_comb begin
        ack_d   = wb_cyc_i & wb_stb_i & ~ack_q;
        wr      = wb_cyc_i & wb_stb_i & wb_we_i & ack_q; // write lands on the ack edge
        gen_hit = (wb_adr_i >= mtm_pkg::ADDR_GEN_LO) && (wb_adr_i <= mtm_pkg::ADDR_GEN_HI);
        gi      = 2'(wb_adr_i[5:4] - 2'h1);
        adv_d   = adv_q;
        sel_d   = sel_q;
        harm_d  = harm_q;
        phase_d = phase_q;
        amp_d   = amp_q;
        rd_d    = 32'h0000_0000; // unmapped reads answer zero
        m       = 32'h0000_0000;
        if (wr && wb_adr_i == mtm_pkg::ADDR_CTRL) begin
            m     = mtm_merge({31'h0, adv_q}, wb_dat_i, wb_sel_i);
            adv_d = m[mtm_pkg::CTRL_ADV_BIT];
        end else if (wr && gen_hit) begin
            unique case (wb_adr_i[3:0])
                mtm_pkg::OFF_CFG: begin // each generator set on its own
                    m = mtm_merge({6'h0, harm_q[gi], 12'h0, sel_q[gi]}, wb_dat_i, wb_sel_i);
                    sel_d[gi]  = m[mtm_pkg::CFG_SEL_LSB +: 4];
                    harm_d[gi] = (m[mtm_pkg::CFG_HARM_LSB +: 10] < mtm_pkg::HARM_MIN) ?
                                 mtm_pkg::HARM_MIN : m[mtm_pkg::CFG_HARM_LSB +: 10];
                end
                mtm_pkg::OFF_PHASE: begin
                    m = mtm_merge({16'h0, phase_q[gi]}, wb_dat_i, wb_sel_i);
                    phase_d[gi] = m[15:0];
                end
                mtm_pkg::OFF_AMP: begin
                    m = mtm_merge({16'h0, amp_q[gi]}, wb_dat_i, wb_sel_i);
                    amp_d[gi] = m[15:0];
                end
                default: begin // frequency word is read only
                end
            endcase
        end
        if (ack_d && wb_adr_i == mtm_pkg::ADDR_CTRL) begin
            rd_d[mtm_pkg::CTRL_ADV_BIT] = adv_q;
        end else if (ack_d && wb_adr_i == mtm_pkg::ADDR_STATUS) begin
            rd_d[mtm_pkg::STAT_ADV_BIT]     = adv_q;
            rd_d[mtm_pkg::STAT_IDX_LSB +: 2] = idx_q;
            rd_d[mtm_pkg::STAT_CH_LSB +: 4]  = 4'(N_CHANNELS);
        end else if (ack_d && gen_hit) begin
            unique case (wb_adr_i[3:0])
                mtm_pkg::OFF_CFG:   rd_d = {6'h0, harm_q[gi], 12'h0, sel_q[gi]};
                mtm_pkg::OFF_PHASE: rd_d = {16'h0, phase_q[gi]};
                mtm_pkg::OFF_AMP:   rd_d = {16'h0, amp_q[gi]};
                mtm_pkg::OFF_FREQ:  rd_d = {2'h0, osc_hz_i[sel_q[gi]]};
                default:            rd_d = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q   <= 1'b0;
            rd_q    <= 32'h0000_0000;
            adv_q   <= mtm_pkg::CTRL_RESET;
            harm_q  <= {G{mtm_pkg::HARM_MIN}};
            phase_q <= {G{mtm_pkg::PHASE_RESET}};
            amp_q   <= {G{mtm_pkg::AMP_RESET}};
            for (int g = 0; g < G; g++) sel_q[g] <= 4'(g);
        end else begin
            ack_q   <= ack_d;
            rd_q    <= rd_d;
            adv_q   <= adv_d;
            sel_q   <= sel_d;
            harm_q  <= harm_d;
            phase_q <= phase_d;
            amp_q   <= amp_d;
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = rd_q;

    // four carriers, frequency = linked oscillator times harmonic
    for (genvar g = 0; g < G; g++) begin : gen_carrier
        assign inc_w[g] = 32'(osc_inc_i[sel_q[g]] * harm_q[g]);
        mtm_sine_gen u_sine (
            .clk_i    (clk_i),
            .rst_i    (rst_i),
            .tick_i   (sample_valid_i),
            .inc_i    (inc_w[g]),
            .offset_i (phase_q[g]),
            .sin_o    (sin_w[g])
        );
    end

    // de-interleave, multiply, sum
    always_comb begin
        logic signed [31:0] p;
        logic signed [32:0] q;
        p       = 32'sh0;
        q       = 33'sh0;
        idx_d   = idx_q;
        env_d   = env_q;
        byp_d   = byp_q;
        adv_t_d = adv_t_q;
        dac_d   = dac_q;
        sum_w   = 18'sh0;
        if (!adv_q) begin
            idx_d = 2'h0; // restart the deal at stream zero
            env_d = '0;
        end else if (sample_valid_i) begin
            env_d[idx_q] = sample_i;
            idx_d        = idx_q + 2'h1;
        end
        if (sample_valid_i) begin
            byp_d   = sample_i;
            adv_t_d = adv_q;
        end
        for (int g = 0; g < G; g++) begin
            p     = 32'($signed(env_q[g])) * 32'(sin_w[g]);
            q     = 33'($signed(p[30:15])) * 33'($signed({1'b0, amp_q[g]}));
            sum_w = sum_w + $signed(q[32:15]); // signed share, keeps negative products
        end
        if (tick_q) begin
            dac_d = adv_t_q ? sum_w : {{2{byp_q[15]}}, byp_q};
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            idx_q   <= 2'h0;
            env_q   <= '0;
            byp_q   <= 16'h0000;
            tick_q  <= 1'b0;
            adv_t_q <= 1'b0;
            dac_q   <= 18'h00000;
            vld_q   <= 1'b0;
        end else begin
            idx_q   <= idx_d;
            env_q   <= env_d;
            byp_q   <= byp_d;
            tick_q  <= sample_valid_i;
            adv_t_q <= adv_t_d;
            dac_q   <= dac_d;
            vld_q   <= tick_q;
        end
    end

    assign dac_o       = dac_q;
    assign dac_valid_o = vld_q;

    // checks on the datapath and register effects
    a_bypass_pass: assert property (@(posedge clk_i) disable iff (rst_i)
        (sample_valid_i && !adv_q) |-> ##2 (dac_valid_o && dac_o == {{2{$past(sample_i[15], 2)}}, $past(sample_i, 2)}))
        else $error("bypass sample not forwarded unchanged");
    a_idx_rotate: assert property (@(posedge clk_i) disable iff (rst_i)
        (sample_valid_i && adv_q) |=> idx_q == 2'($past(idx_q) + 2'h1))
        else $error("sub-stream index did not advance");
    a_env_capture: assert property (@(posedge clk_i) disable iff (rst_i)
        (sample_valid_i && adv_q) |=> env_q[$past(idx_q)] == $past(sample_i))
        else $error("sample not stored in its sub-stream");
    a_sum_out: assert property (@(posedge clk_i) disable iff (rst_i)
        (sample_valid_i && adv_q) ##1 1'b1 |=> (dac_valid_o && dac_o == $past(sum_w)))
        else $error("converter word is not the carrier sum");
    a_harm_range: assert property (@(posedge clk_i) disable iff (rst_i)
        harm_q[0] >= mtm_pkg::HARM_MIN && harm_q[1] >= mtm_pkg::HARM_MIN &&
        harm_q[2] >= mtm_pkg::HARM_MIN && harm_q[3] >= mtm_pkg::HARM_MIN)
        else $error("harmonic factor below one");
    a_freq_read: assert property (@(posedge clk_i) disable iff (rst_i)
        (ack_d && !wb_we_i && wb_adr_i == (mtm_pkg::ADDR_GEN_LO | 8'(mtm_pkg::OFF_FREQ))) |=>
        (wb_ack_o && wb_dat_o == {2'h0, $past(osc_hz_i[sel_q[0]])}))
        else $error("frequency readback mismatch");
    a_phase_write: assert property (@(posedge clk_i) disable iff (rst_i)
        (wr && wb_sel_i == 4'hf && wb_adr_i == (mtm_pkg::ADDR_GEN_LO | 8'(mtm_pkg::OFF_PHASE))) |=>
        phase_q[0] == $past(wb_dat_i[15:0]))
        else $error("phase offset not stored");
    a_idx_idle: assert property (@(posedge clk_i) disable iff (rst_i)
        !adv_q |=> (idx_q == 2'h0 && env_q == '0))
        else $error("sub-streams not cleared outside advanced mode");
    a_out_latency: assert property (@(posedge clk_i) disable iff (rst_i)
        sample_valid_i |-> ##2 dac_valid_o)
        else $error("output word missing two cycles after a sample");

    c_adv_out: cover property (@(posedge clk_i) disable iff (rst_i) dac_valid_o && adv_t_q);
    c_byp_out: cover property (@(posedge clk_i) disable iff (rst_i) dac_valid_o && !adv_t_q);
    c_full_round: cover property (@(posedge clk_i) disable iff (rst_i) sample_valid_i && adv_q && idx_q == 2'h3);
    c_harm_write: cover property (@(posedge clk_i) disable iff (rst_i) wr && gen_hit && wb_adr_i[3:0] == 4'h0);
endmodule

// ==== mtm_pkg.sv ====
package mtm_pkg;
    // build shape
    localparam int          NUM_GEN      = 4;
    localparam int          NUM_OSC      = 16;
    localparam int          CH_COUNT_LO  = 4;
    localparam int          CH_COUNT_HI  = 8;
    // register byte offsets
    localparam logic [7:0]  ADDR_CTRL    = 8'h00;
    localparam logic [7:0]  ADDR_STATUS  = 8'h04;
    localparam logic [7:0]  ADDR_GEN_LO  = 8'h10;
    localparam logic [7:0]  ADDR_GEN_HI  = 8'h4c;
    localparam logic [3:0]  OFF_CFG      = 4'h0;
    localparam logic [3:0]  OFF_PHASE    = 4'h4;
    localparam logic [3:0]  OFF_AMP      = 4'h8;
    localparam logic [3:0]  OFF_FREQ     = 4'hc;
    // field positions
    localparam int          CTRL_ADV_BIT = 0;
    localparam int          CFG_SEL_LSB  = 0;
    localparam int          CFG_HARM_LSB = 16;
    localparam int          STAT_ADV_BIT = 0;
    localparam int          STAT_IDX_LSB = 4;
    localparam int          STAT_CH_LSB  = 8;
    // reset values and limits
    localparam logic        CTRL_RESET   = 1'b0;
    localparam logic [9:0]  HARM_MIN     = 10'h001;
    localparam logic [9:0]  HARM_MAX     = 10'h3ff;
    localparam logic [15:0] PHASE_RESET  = 16'h0000;
    localparam logic [15:0] AMP_RESET    = 16'h7fff;
    localparam logic [29:0] FREQ_MAX_HZ  = 30'h2cb41780;
    // latency of the datapath, sample in to converter word out
    localparam int          PIPE_DEPTH   = 2;
endpackage

// ==== mtm_sine_gen.sv ====
`timescale 1ns/10ps
module mtm_sine_gen (
    input  wire logic               clk_i,
    input  wire logic               rst_i,
    input  wire logic               tick_i,
    input  wire logic        [31:0] inc_i,
    input  wire logic        [15:0] offset_i,
    output logic signed      [15:0] sin_o
);
    logic        [31:0] acc_q;
    logic        [31:0] acc_d;
    logic signed [15:0] sin_q;
    logic signed [15:0] sin_d;
    logic signed [15:0] x;
    logic        [16:0] ax;
    logic signed [33:0] prod;

    // phase accumulator plus offset, parabolic sine of the sum
    always_comb begin
        acc_d = acc_q;
        sin_d = sin_q;
        x     = 16'(acc_q[31:16] + offset_i); // full turn is 2^16
        ax    = x[15] ? 17'(-$signed({x[15], x})) : {1'b0, x};
        // x * (half turn - |x|) peaks at a quarter turn and is zero at 0 and 180 degrees
        prod  = 34'($signed({x[15], x})) * 34'($signed({1'b0, 17'h08000 - ax}));
        if (tick_i) begin
            acc_d = acc_q + inc_i;
            if ($signed(prod[33:13]) > 21'sh7fff) begin
                sin_d = 16'sh7fff; // peak would wrap to -32768
            end else begin
                sin_d = prod[28:13];
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            acc_q <= 32'h0000_0000;
            sin_q <= 16'sh0000;
        end else begin
            acc_q <= acc_d;
            sin_q <= sin_d;
        end
    end

    assign sin_o = sin_q;
endmodule

// ==== test_multi_tone_output_modulator.sv ====
`timescale 1ns/10ps
module test_multi_tone_output_modulator;
    logic        clk_i;
    logic        rst_i;
    logic        wb_cyc_i;
    logic        wb_stb_i;
    logic        wb_we_i;
    logic [7:0]  wb_adr_i;
    logic [3:0]  wb_sel_i;
    logic [31:0] wb_dat_i;
    logic [31:0] wb_dat_o;
    logic        wb_ack_o;
    logic [31:0] osc_inc_i [mtm_pkg::NUM_OSC];
    logic [29:0] osc_hz_i  [mtm_pkg::NUM_OSC];
    logic [15:0] sample_i;
    logic        sample_valid_i;
    logic [17:0] dac_o;
    logic        dac_valid_o;
    logic [31:0] dac_count;
    logic [17:0] dac_last;
    logic [31:0] last_exp;
    logic [31:0] seed;
    logic [31:0] exq [$];
    int          num_errors;
    int          n_tests;
    int          env [4];
    int          pk  [4];
    int          amp [4];
    int          idx;
    int          sent;
    bit          adv;

    mtm_modulator #(.N_CHANNELS(8)) dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
        .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .osc_inc_i(osc_inc_i),
        .osc_hz_i(osc_hz_i), .sample_i(sample_i), .sample_valid_i(sample_valid_i),
        .dac_o(dac_o), .dac_valid_o(dac_valid_o));
    mtm_dac_model conv (.clk_i(clk_i), .rst_i(rst_i), .dac_i(dac_o), .valid_i(dac_valid_o),
        .count_o(dac_count), .last_o(dac_last));

    // free-running 25 MHz clock
    initial begin
        clk_i = 1'b0;
        forever #20 clk_i = ~clk_i;
    end

    function automatic logic [31:0] lfsr(logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction

    // one generator's share: envelope times carrier times amplitude
    function automatic int prod(int g);
        return (((env[g] * pk[g]) >>> 15) * amp[g]) >>> 15;
    endfunction

    task automatic conclude();
        $display("comparisons %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic chk(logic [31:0] got, logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // classic single wishbone cycle, waits for ack under a bound
    task automatic wb(logic we, logic [7:0] a, logic [31:0] d, logic [3:0] s, output logic [31:0] r);
        int k;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        wb_sel_i <= s;
        for (k = 0; k < 16; k++) begin
            @(posedge clk_i);
            if (wb_ack_o === 1'b1) break;
        end
        r = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i  <= 1'b0;
        if (k == 16) begin
            num_errors++;
            conclude();
        end
    endtask

    task automatic rd(logic [7:0] a, logic [31:0] exp);
        logic [31:0] r;
        wb(1'b0, a, 32'h0, 4'h0, r);
        chk(r, exp);
    endtask

    task automatic wr(logic [7:0] a, logic [31:0] d, logic [3:0] s);
        logic [31:0] r;
        wb(1'b1, a, d, s, r);
    endtask

    // mode change also restarts the sub-stream deal and envelopes
    task automatic set_mode(bit m);
        wr(mtm_pkg::ADDR_CTRL, {31'h0, m}, 4'hf);
        adv = m;
        idx = 0;
        env = '{0, 0, 0, 0};
    endtask

    // back-to-back random samples with the expected words queued
    task automatic send(int n);
        int e;
        for (int i = 0; i < n; i++) begin
            @(posedge clk_i);
            seed = lfsr(seed);
            sample_valid_i <= 1'b1;
            sample_i <= seed[15:0];
            e = int'($signed(seed[15:0]));
            if (adv) begin
                env[idx] = e;
                idx = (idx + 1) % 4;
                e = 0;
                for (int g = 0; g < 4; g++) e += prod(g);
            end
            exq.push_back(32'(e) & 32'h3ffff);
            sent++;
        end
        @(posedge clk_i);
        sample_valid_i <= 1'b0;
        repeat (3) @(posedge clk_i);
        chk(32'(exq.size()), 32'h0);
    endtask

    // compare every converter word with the model
    always @(posedge clk_i) begin
        if (dac_valid_o === 1'b1) begin
            if (exq.size() == 0)
                chk(32'h1, 32'h0);
            else begin
                last_exp = exq.pop_front();
                chk({14'h0, dac_o}, last_exp);
            end
        end
    end

    initial begin
        seed = 32'hca096e4a;
        {wb_cyc_i, wb_stb_i, wb_we_i, sample_valid_i} = 4'h0;
        {wb_adr_i, wb_sel_i, wb_dat_i, sample_i} = '0;
        for (int o = 0; o < mtm_pkg::NUM_OSC; o++) begin
            osc_inc_i[o] = 32'h0;
            osc_hz_i[o] = (o == 15) ? mtm_pkg::FREQ_MAX_HZ : 30'(o * 12345 + 7);
        end
        pk = '{0, 0, 0, 0};
        amp = '{32767, 32767, 32767, 32767};
        rst_i = 1'b1;
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        // reset contents of all four generators
        for (int g = 0; g < 4; g++) begin
            rd(8'(8'h10 + 16 * g), 32'(g) | 32'h10000);
            rd(8'(8'h14 + 16 * g), 32'h0);
            rd(8'(8'h18 + 16 * g), 32'h7fff);
            rd(8'(8'h1c + 16 * g), {2'b0, osc_hz_i[g]});
        end
        rd(8'h00, 32'h0);
        wr(8'h04, 32'hffffffff, 4'hf);
        rd(8'h04, 32'h800);
        rd(8'h08, 32'h0);
        // harmonic limits, byte merge and read-only frequency
        wr(8'h10, 32'h0, 4'hf);
        rd(8'h10, 32'h10000);
        wr(8'h20, 32'h03ff000f, 4'hf);
        rd(8'h20, 32'h03ff000f);
        rd(8'h2c, {2'b0, mtm_pkg::FREQ_MAX_HZ});
        wr(8'h30, 32'h01550005, 4'h4);
        rd(8'h30, 32'h00550002);
        wr(8'h1c, 32'h1234, 4'hf);
        rd(8'h1c, {2'b0, osc_hz_i[0]});
        send(12);
        // advanced mode, carriers at zero phase give silence
        set_mode(1'b1);
        send(11);
        rd(8'h04, 32'h831);
        // carriers at a quarter turn, one muted, one at half scale
        for (int g = 0; g < 4; g++) begin
            wr(8'(8'h14 + 16 * g), 32'h4000, 4'hf);
            pk[g] = 32767;
        end
        wr(8'h38, 32'h0, 4'hf);
        wr(8'h18, 32'h4000, 4'hf);
        amp[2] = 0;
        amp[0] = 16384;
        send(40);
        set_mode(1'b0);
        send(20);
        chk(dac_count, 32'(sent));
        chk({14'h0, dac_last}, last_exp);
        conclude();
    end
endmodule
